// File: pkg/cnp_map.svh
// Register map, codes and reset values for the configuration NVM programming control.
// Assumes inclusion by bare name from the design file; holds definitions only.
// Summary of operation
// - Config locations 0x01-0x0A accept writes only while control holds 0x41.
// - Control value 0x62 enables pre-read of the stored configuration data.
// - Control register resets to 0x00: programming and pre-read both disabled.
// - Serial clock and data lines work only while port-enable pin is high.
// - Commit pin pulsed high then low while control holds 0x41 copies config registers into storage.
// - Column parity over settings and trim data checked against write-time value.
// - Parity mismatch forces discharge and charge FET drives off.
`ifndef CNP_MAP_SVH
`define CNP_MAP_SVH

`define CNP_I2C_ADDR      7'h10
`define CNP_STATUS_OFS    8'h00
`define CNP_CFG_FIRST_OFS 8'h01
`define CNP_CFG_LAST_OFS  8'h0a
`define CNP_CTRL_OFS      8'h0b
`define CNP_CTRL_RESET    8'h00
`define CNP_UNLOCK_CODE   8'h41
`define CNP_PREREAD_CODE  8'h62
`define CNP_CFG_RESET     8'h00
`define CNP_STAT_FAULT    0
`define CNP_STAT_ARMED    1
`define CNP_STAT_PREREAD  2

`endif

// File: pkg/cnp_pkg.sv
// Types shared by the configuration NVM programming control.
// Assumes the offsets and codes come from cnp_map.svh.
package cnp_pkg;

    // Serial slave protocol position
    typedef enum logic [3:0] {
        CNP_IDLE,
        CNP_ADDR,
        CNP_ADDR_ACK,
        CNP_PTR,
        CNP_PTR_ACK,
        CNP_WDATA,
        CNP_WDATA_ACK,
        CNP_RDATA,
        CNP_RDATA_ACK
    } cnp_i2c_state_e;

    // Power FET pair, request or drive
    typedef struct packed {
        logic discharge_fet_drive;
        logic charge_fet_drive;
    } cnp_fet_s;

endpackage

// File: testbench/cnp_host_model.sv
// Serial host model: drives clock, open-drain data and the commit pin.
// Assumes a pull-up on the data wire; phases are slow against clk_in.
module cnp_host_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out = 1'h1,
    output logic      sda_oe_n_out = 1'h1,
    output logic      commit_out = 1'h0
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bit level: data moves mid low phase, well clear of clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic put_bit(input logic b);
        sda_oe_n_out <= b;
        tick(4);
        scl_out <= 1'h1;
        tick(8);
        scl_out <= 1'h0;
        tick(4);
    endtask
    task automatic get_bit(output logic b);
        sda_oe_n_out <= 1'h1;
        tick(4);
        scl_out <= 1'h1;
        tick(4);
        b = sda_in;
        tick(4);
        scl_out <= 1'h0;
        tick(4);
    endtask
    task automatic start();
        sda_oe_n_out <= 1'h1;
        tick(4);
        scl_out <= 1'h1;
        tick(8);
        sda_oe_n_out <= 1'h0;
        tick(8);
        scl_out <= 1'h0;
        tick(4);
    endtask
    task automatic stop();
        sda_oe_n_out <= 1'h0;
        tick(4);
        scl_out <= 1'h1;
        tick(8);
        sda_oe_n_out <= 1'h1;
        tick(8);
    endtask
    // Byte level: MSB first, ninth bit is the acknowledge
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        ack = !a;
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, output logic ack);
        logic a;
        start();
        put_byte(8'h20, a);
        put_byte(ofs, a);
        put_byte(d, ack);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        start();
        put_byte(8'h20, a);
        put_byte(ofs, a);
        start();
        put_byte(8'h21, a);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'h1);
        stop();
    endtask
    // Commit: high then low, issued both while armed and after control is set to 0x33
    task automatic pulse_commit();
        commit_out <= 1'h1;
        tick(8);
        commit_out <= 1'h0;
        tick(8);
    endtask
endmodule

// File: testbench/cnp_nvm_ctrl_monitor.sv
// Port checker for the configuration NVM programming control.
// Assumes storage is never disturbed from outside, so parity never trips.
module cnp_nvm_ctrl_monitor (
    input wire logic         clk_in,
    input wire logic         reset_n_in,
    input wire logic         serial_port_enable_pin_in,
    input wire logic         scl_in,
    input wire logic         sda_in,
    input wire logic         sda_out,
    input wire logic         sda_oe_n_out,
    input wire logic         commit_pin_in,
    input cnp_pkg::cnp_fet_s fet_req_in,
    input cnp_pkg::cnp_fet_s fet_drive_out,
    input wire logic [7:0]   nvm_ctrl_out
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    // Control register and serial port; sync delays allow a few cycles of lag
    AST_CTRL_RESET: assert property ($rose(reset_n_in) |-> nvm_ctrl_out == 8'h00)
        else $error("control not clear after reset");
    AST_PORT_OFF: assert property (!serial_port_enable_pin_in [*6] |-> sda_oe_n_out)
        else $error("data line pulled while port disabled");
    AST_CTRL_PORT: assert property (
        $changed(nvm_ctrl_out) |-> $past(serial_port_enable_pin_in, 4))
        else $error("control changed with port disabled");
    AST_ACK_PHASE: assert property ($fell(sda_oe_n_out) |-> !$past(scl_in, 2))
        else $error("data line pulled while clock high");
    AST_CTRL_QUIET: assert property (scl_in [*8] |=> $stable(nvm_ctrl_out))
        else $error("control changed without serial traffic");
    AST_COMMIT_CTRL: assert property (commit_pin_in |-> $stable(nvm_ctrl_out))
        else $error("commit pulse altered control");

    // FET drives: requests pass one cycle later unless parity trips
    AST_FET_FOLLOW: assert property (
        $past(reset_n_in) && $past(reset_n_in, 2) |-> fet_drive_out == $past(fet_req_in))
        else $error("fet drive differs from request with intact parity");
    AST_FET_OFF: assert property ((fet_drive_out & ~$past(fet_req_in)) == 2'h0)
        else $error("fet driven on without request");
endmodule

bind cnp_nvm_ctrl cnp_nvm_ctrl_monitor i_mon (.clk_in, .reset_n_in, .serial_port_enable_pin_in,
    .scl_in, .sda_in, .sda_out, .sda_oe_n_out, .commit_pin_in, .fet_req_in, .fet_drive_out,
    .nvm_ctrl_out);

// File: testbench/cnp_nvm_ctrl_tb_top.sv
// Self-checking bench for the NVM programming control.
// Assumes the host model for serial traffic and a pull-up on the data wire.
module cnp_nvm_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk_in = 1'h0;
    logic              reset_n_in = 1'h0;
    logic              port_en = 1'h0;
    logic              scl;
    logic              host_oe_n;
    logic              dut_oe_n;
    logic              dut_sda;
    logic              commit;
    cnp_pkg::cnp_fet_s fet_req = 2'h0;
    cnp_pkg::cnp_fet_s fet_drive;
    logic [7:0]        ctrl;
    logic [7:0]        rd;
    logic              ack;
    int                failures = 0;
    int                comparisons = 0;
    // Open drain: the design shows its data value only while enabled, else pull-up
    wire               sda_wire = host_oe_n & (dut_oe_n | dut_sda);

    always #12.5 clk_in = ~clk_in;

    cnp_nvm_ctrl i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .serial_port_enable_pin_in(port_en), .scl_in(scl), .sda_in(sda_wire), .sda_out(dut_sda),
        .sda_oe_n_out(dut_oe_n), .commit_pin_in(commit), .fet_req_in(fet_req),
        .fet_drive_out(fet_drive), .nvm_ctrl_out(ctrl));
    cnp_host_model i_host (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_oe_n_out(host_oe_n), .commit_out(commit));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog: whole sequence needs roughly 10600 cycles
    initial begin
        repeat (60000) @(posedge clk_in);
        failures++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_in);
        reset_n_in <= 1'h1;
        port_en <= 1'h1;
        repeat (4) @(posedge clk_in);
        i_host.read_reg(8'h0b, rd);
        check("ctrl reset", rd, 8'h00);
        i_host.write_reg(8'h01, 8'ha5, ack);
        i_host.read_reg(8'h01, rd);
        check("locked cfg", rd, 8'h00);
        i_host.write_reg(8'h0b, 8'h41, ack);
        check("ctrl out", ctrl, 8'h41);
        i_host.write_reg(8'h01, 8'ha5, ack);
        i_host.write_reg(8'h0a, 8'h3c, ack);
        check("write ack", {7'h00, ack}, 8'h01);
        i_host.read_reg(8'h0a, rd);
        check("armed cfg", rd, 8'h3c);
        i_host.write_reg(8'h0b, 8'h41, ack);
        i_host.pulse_commit();
        i_host.read_reg(8'h00, rd);
        check("status armed", rd, 8'h02);
        i_host.write_reg(8'h01, 8'h11, ack);
        i_host.write_reg(8'h0b, 8'h33, ack);
        i_host.pulse_commit();
        i_host.write_reg(8'h0b, 8'h62, ack);
        i_host.read_reg(8'h00, rd);
        check("status preread", rd, 8'h04);
        i_host.read_reg(8'h01, rd);
        check("stored low", rd, 8'ha5);
        i_host.read_reg(8'h0a, rd);
        check("stored high", rd, 8'h3c);
        i_host.write_reg(8'h0b, 8'h00, ack);
        i_host.read_reg(8'h01, rd);
        check("shadow cfg", rd, 8'h11);
        i_host.read_reg(8'h0c, rd);
        check("unmapped", rd, 8'h00);
        port_en <= 1'h0;
        i_host.write_reg(8'h0b, 8'h41, ack);
        check("port off ack", {7'h00, ack}, 8'h00);
        check("port off ctrl", ctrl, 8'h00);
        port_en <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            fet_req <= 2'(i);
            repeat (3) @(posedge clk_in);
            check("fet drive", {6'h00, fet_drive}, 8'(i));
        end
        conclude();
    end
endmodule

// File: verilog/cnp_nvm_ctrl.sv
// Configuration NVM programming control with its serial register port.
// Assumes a 40 MHz clk_in; serial lines, port enable and commit pin are asynchronous pins;
// FET requests come from protection logic on the same clock.
`include "cnp_map.svh"

module cnp_nvm_ctrl #(
    parameter int          CFG_COUNT = 10,
    parameter logic [7:0]  TRIM_DATA = 8'h5a  // Arbitrary trim pattern held in storage
) (
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    input  wire logic              serial_port_enable_pin_in,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n_out,
    input  wire logic              commit_pin_in,
    input  cnp_pkg::cnp_fet_s      fet_req_in,
    output cnp_pkg::cnp_fet_s      fet_drive_out,
    output logic [7:0]             nvm_ctrl_out
);

    // Column parity over a set of stored bytes plus the trim byte
    function automatic logic [7:0] col_parity(input logic [7:0] mem [CFG_COUNT],
                                              input logic [7:0] trim);
        logic [7:0] acc;
        acc = trim;
        for (int i = 0; i < CFG_COUNT; i++) begin
            acc = acc ^ mem[i];
        end
        return acc;
    endfunction

    // Pin synchronisers, two flops each; stage one is read only by stage two
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic       scl_prev;
    logic       sda_prev;
    logic       commit_prev;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {commit_pin_in, serial_port_enable_pin_in, sda_in, scl_in};
            sync2 <= sync1;
        end
    end

    // Lines look idle-high while the port is disabled, so no traffic is decoded
    wire port_en  = sync2[2];
    wire scl_s    = sync2[0] | ~port_en;
    wire sda_s    = sync2[1] | ~port_en;
    wire commit_s = sync2[3];
    wire scl_rise = scl_s & ~scl_prev;
    wire scl_fall = ~scl_s & scl_prev;
    wire start_c  = scl_s & scl_prev & sda_prev & ~sda_s;
    wire stop_c   = scl_s & scl_prev & ~sda_prev & sda_s;

    // Register state
    logic [7:0] ctrl;
    logic [7:0] shadow [CFG_COUNT];
    logic [7:0] nvm [CFG_COUNT];
    logic [7:0] nvm_trim;
    logic [7:0] nvm_par;
    logic       fault;

    wire armed   = (ctrl == `CNP_UNLOCK_CODE);
    wire preread = (ctrl == `CNP_PREREAD_CODE);

    // Serial slave state
    cnp_pkg::cnp_i2c_state_e state;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic [7:0] ptr;
    logic       rw_read;
    logic [7:0] rx_byte_q;  // Byte captured on the eighth rising clock
    logic [7:0] rd_next;    // Read data of the following location

    wire [7:0] rx_byte = {shreg[6:0], sda_s};
    wire       byte_in = scl_rise && (bit_cnt == 4'd7);

    // Register read decode
    wire       ptr_cfg  = (ptr >= `CNP_CFG_FIRST_OFS) && (ptr <= `CNP_CFG_LAST_OFS);
    wire [7:0] cfg_idx  = ptr - `CNP_CFG_FIRST_OFS;
    wire [7:0] cfg_rd   = preread ? nvm[cfg_idx[3:0]] : shadow[cfg_idx[3:0]];
    wire [7:0] stat_rd  = {5'h00, preread, armed, fault};
    logic [7:0] rd_data;
    always_comb begin
        if (ptr == `CNP_STATUS_OFS) begin
            rd_data = stat_rd;
        end else if (ptr_cfg) begin
            rd_data = cfg_rd;
        end else if (ptr == `CNP_CTRL_OFS) begin
            rd_data = ctrl;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Write decode at the end of a data byte
    wire wr_stb   = (state == cnp_pkg::CNP_WDATA) && scl_fall && (bit_cnt == 4'd8);
    wire wr_ctrl  = wr_stb && (ptr == `CNP_CTRL_OFS);
    wire wr_cfg   = wr_stb && ptr_cfg && armed;

    // Commit on falling edge of the pin, taken only if armed at that falling edge
    wire commit_fall = commit_prev & ~commit_s;
    wire do_commit   = commit_fall && armed;
    wire [7:0] next_par = col_parity(shadow, nvm_trim);
    wire [7:0] live_par = col_parity(nvm, nvm_trim);
    wire       next_fault = (live_par != nvm_par);

    // Edge history
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_prev    <= 1'b1;
            sda_prev    <= 1'b1;
            commit_prev <= 1'b0;
        end else begin
            scl_prev    <= scl_s;
            sda_prev    <= sda_s;
            commit_prev <= commit_s;
        end
    end

    // Control register and shadow configuration
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl <= `CNP_CTRL_RESET;
            for (int i = 0; i < CFG_COUNT; i++) begin
                shadow[i] <= `CNP_CFG_RESET;
            end
        end else begin
            if (wr_ctrl) begin
                ctrl <= rx_byte_q;
            end
            if (wr_cfg) begin
                shadow[cfg_idx[3:0]] <= rx_byte_q;
            end
        end
    end

    // Storage array; flops stand in for the cells, so reset models a blank part
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < CFG_COUNT; i++) begin
                nvm[i] <= `CNP_CFG_RESET;
            end
            nvm_trim <= TRIM_DATA;
            nvm_par  <= TRIM_DATA;
        end else if (do_commit) begin
            for (int i = 0; i < CFG_COUNT; i++) begin
                nvm[i] <= shadow[i];
            end
            nvm_par <= next_par;
        end
    end

    // Fault register and FET drives; fault is recomputed every cycle, so a flip shows in two
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault         <= 1'b0;
            fet_drive_out <= '0;
            nvm_ctrl_out  <= `CNP_CTRL_RESET;
        end else begin
            fault                             <= next_fault;
            fet_drive_out.discharge_fet_drive <= fet_req_in.discharge_fet_drive & ~fault;
            fet_drive_out.charge_fet_drive    <= fet_req_in.charge_fet_drive & ~fault;
            nvm_ctrl_out                      <= ctrl;
        end
    end

    // Serial slave: sample on rising clock, change data on falling clock
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state        <= cnp_pkg::CNP_IDLE;
            shreg        <= 8'h00;
            rx_byte_q    <= 8'h00;
            bit_cnt      <= 4'd0;
            ptr          <= 8'h00;
            rw_read      <= 1'b0;
            sda_out      <= 1'b0;
            sda_oe_n_out <= 1'b1;
        end else if (!port_en || stop_c) begin
            state        <= cnp_pkg::CNP_IDLE;
            bit_cnt      <= 4'd0;
            sda_oe_n_out <= 1'b1;
        end else if (start_c) begin
            state        <= cnp_pkg::CNP_ADDR;
            bit_cnt      <= 4'd0;
            sda_oe_n_out <= 1'b1;
        end else if (scl_rise) begin
            if (bit_cnt != 4'd8) begin
                shreg   <= rx_byte;
                bit_cnt <= bit_cnt + 4'd1;
            end
            if (byte_in) begin
                rx_byte_q <= rx_byte;
            end
            if (state == cnp_pkg::CNP_RDATA_ACK && sda_s) begin
                state <= cnp_pkg::CNP_IDLE;                       // Master refused more data
            end
        end else if (scl_fall) begin
            case (state)
                cnp_pkg::CNP_ADDR: begin
                    if (bit_cnt == 4'd8) begin
                        if (rx_byte_q[7:1] == `CNP_I2C_ADDR) begin
                            rw_read      <= rx_byte_q[0];
                            sda_oe_n_out <= 1'b0;
                            state        <= cnp_pkg::CNP_ADDR_ACK;
                        end else begin
                            state <= cnp_pkg::CNP_IDLE;
                        end
                    end
                end
                cnp_pkg::CNP_ADDR_ACK: begin
                    bit_cnt <= 4'd0;
                    if (rw_read) begin
                        shreg        <= rd_data;              // Rising clocks shift it along
                        sda_oe_n_out <= rd_data[7];
                        state        <= cnp_pkg::CNP_RDATA;
                    end else begin
                        sda_oe_n_out <= 1'b1;
                        state        <= cnp_pkg::CNP_PTR;
                    end
                end
                cnp_pkg::CNP_PTR, cnp_pkg::CNP_WDATA: begin
                    if (bit_cnt == 4'd8) begin
                        sda_oe_n_out <= 1'b0;
                        if (state == cnp_pkg::CNP_PTR) begin
                            ptr   <= rx_byte_q;
                            state <= cnp_pkg::CNP_PTR_ACK;
                        end else begin
                            state <= cnp_pkg::CNP_WDATA_ACK;
                        end
                    end
                end
                cnp_pkg::CNP_PTR_ACK, cnp_pkg::CNP_WDATA_ACK: begin
                    if (state == cnp_pkg::CNP_WDATA_ACK) begin
                        ptr <= ptr + 8'h01;
                    end
                    bit_cnt      <= 4'd0;
                    sda_oe_n_out <= 1'b1;
                    state        <= cnp_pkg::CNP_WDATA;
                end
                cnp_pkg::CNP_RDATA: begin
                    if (bit_cnt == 4'd8) begin
                        sda_oe_n_out <= 1'b1;
                        state        <= cnp_pkg::CNP_RDATA_ACK;
                    end else begin
                        sda_oe_n_out <= shreg[7];             // Already shifted on the rise
                    end
                end
                cnp_pkg::CNP_RDATA_ACK: begin
                    // Master acknowledged: load the next byte, pointer walks upward
                    bit_cnt      <= 4'd0;
                    shreg        <= rd_next;
                    sda_oe_n_out <= rd_next[7];
                    ptr          <= ptr + 8'h01;
                    state        <= cnp_pkg::CNP_RDATA;
                end
                default: begin
                    state <= cnp_pkg::CNP_IDLE;
                end
            endcase
        end
    end

    // Read data of the following location, for back-to-back reads
    wire  [7:0] ptr_nx    = ptr + 8'h01;
    wire  [7:0] nx_idx    = ptr_nx - `CNP_CFG_FIRST_OFS;
    wire        nx_cfg    = (ptr_nx >= `CNP_CFG_FIRST_OFS) && (ptr_nx <= `CNP_CFG_LAST_OFS);
    wire  [7:0] nx_cfg_rd = preread ? nvm[nx_idx[3:0]] : shadow[nx_idx[3:0]];
    always_comb begin
        if (ptr_nx == `CNP_STATUS_OFS) begin
            rd_next = stat_rd;
        end else if (nx_cfg) begin
            rd_next = nx_cfg_rd;
        end else if (ptr_nx == `CNP_CTRL_OFS) begin
            rd_next = ctrl;
        end else begin
            rd_next = 8'h00;
        end
    end

endmodule
